// File: verilog/msc_stats.sv
// Purpose: Statistics counter bank and user I/O control of an Ethernet MAC
// Assumes: Frame event strobes are one-cycle pulses synchronous to clk_sys_in
// Notes: Counters clear on read and stick at all ones
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module msc_stats (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [msc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [msc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic tx_done_in,
  input wire logic tx_underrun_in,
  input wire logic tx_retry_exceeded_in,
  input wire logic [4:0] tx_collisions_in,
  input wire logic tx_deferred_in,
  input wire logic rx_done_in,
  input wire logic [10:0] rx_length_in,
  input wire logic rx_whole_bytes_in,
  input wire logic rx_crc_bad_in,
  input wire logic rx_symbol_err_in,
  input wire logic rx_is_pause_in,
  input wire logic rx_copied_in,
  input wire logic [15:0] rx_type_field_in,
  output logic rx_type_match_out,
  output logic rmii_select_out,
  input wire logic phy_clk_in,
  output logic phy_clk_gated_out
);
  import msc_pkg::*;

  // ****************************************
  // Behaviour overview
  // ****************************************
  // Register map, all aligned 32-bit words
  // Network control word at the base
  // Type compare word next to it
  // User I/O word after that
  // Eight counters from the pause counter up
  // Unmapped words answer with a slave error
  // Unmapped reads return zero data
  //
  // Counter order inside the bank
  // Slot 0 good pause frames, 16 bits
  // Slot 1 frames sent ok, 24 bits
  // Slot 2 one collision frames, 16 bits
  // Slot 3 two to fifteen collisions, 16 bits
  // Slot 4 good frames copied, 24 bits
  // Slot 5 whole-byte CRC errors, 8 bits
  // Slot 6 odd-bit alignment errors, 8 bits
  // Slot 7 deferred first attempts, 16 bits
  //
  // Counter storage is a full word per slot
  // Only the low field width is ever nonzero
  // Masking on write keeps upper bits clear
  // Masking on read guards the upper bits too
  //
  // Frame strobes are single-cycle pulses
  // Qualifiers must be valid with the strobe
  // A strobe with no qualifier match is ignored
  // Receive counting waits for receive enable
  // Transmit counting is never gated
  //
  // Priority inside one counter slot
  // A counter write beats everything else
  // A read clear beats a plain increment
  // A frame on the read-clear cycle is kept as one
  // So no frame is lost across a read
  //
  // Limitation for software
  // A saturated counter hides further frames
  // Poll faster than the shortest fill time
  // The 8-bit error counters fill first at line rate
  //
  // Type compare result
  // Refreshed on every received frame strobe
  // Refreshed even while receive is disabled
  // Holds its value between frames
  //
  // Transceiver clock path
  // Gate is a plain AND with the enable bit
  // Enable changes only on system clock edges
  // A change mid-phase may clip one pulse
  // The transceiver tolerates a short pulse on enable

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] net_ctrl;
    logic [TYPE_ID_W-1:0] type_id;
    logic [1:0] user_io;
    logic [NCNT-1:0][31:0] cnt;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic type_match;
  } msc_state_type;

  localparam int CW [NCNT] = '{W_PAUSE, W_TXOK, W_ONECOL, W_MULTICOL,
                               W_RXOK, W_CRC, W_ALIGN, W_DEFER};
  localparam logic [ADDR_W-1:0] COFS [NCNT] = '{OFS_PAUSE_RX, OFS_TX_OK,
    OFS_ONE_COL, OFS_MULTI_COL, OFS_RX_OK, OFS_CRC_ERR, OFS_ALIGN_ERR,
    OFS_DEFER};

  msc_state_type state_reg;
  msc_state_type state_next;
  logic [NCNT-1:0] event_hit;
  logic [NCNT-1:0] cnt_rd;
  logic [NCNT-1:0] cnt_wr;
  logic [NCNT-1:0][31:0] cnt_mask;
  logic [NCNT-1:0][31:0] cnt_step;
  logic rx_on;
  logic len_ok;
  logic rx_clean;
  logic tx_ok;
  logic wr_go;
  logic rd_go;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_hit;

  // ****************************************
  // Frame event qualification
  // ****************************************
  // Length window widens when big frames are allowed
  assign len_ok = (rx_length_in >= LEN_MIN) &&
    (rx_length_in <= (state_reg.net_ctrl[BIT_BIG_FRAMES] ? LEN_MAX_BIG : LEN_MAX));
  assign rx_on = rx_done_in && state_reg.net_ctrl[BIT_RX_ENABLE];
  assign rx_clean = len_ok && !rx_crc_bad_in && !rx_symbol_err_in;
  assign tx_ok = tx_done_in && !tx_underrun_in && !tx_retry_exceeded_in;

  // Per-counter increment strobes
  always_comb begin
    event_hit = '0;
    event_hit[0] = rx_on && rx_is_pause_in && rx_clean;
    event_hit[1] = tx_ok;
    event_hit[2] = tx_ok && (tx_collisions_in == 5'h01);
    event_hit[3] = tx_ok && (tx_collisions_in >= 5'h02) &&
                   (tx_collisions_in <= COL_MULTI_MAX);
    event_hit[4] = rx_on && rx_copied_in && rx_clean;
    event_hit[5] = rx_on && len_ok && rx_whole_bytes_in &&
                   (rx_crc_bad_in || rx_symbol_err_in);
    event_hit[6] = rx_on && len_ok && !rx_whole_bytes_in &&
                   (rx_crc_bad_in || rx_symbol_err_in);
    event_hit[7] = tx_done_in && tx_deferred_in && !tx_underrun_in &&
                   (tx_collisions_in == 5'h00);
  end

  // ****************************************
  // Bus decode
  // ****************************************
  assign wr_go = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign rd_go = s_axi_arvalid_in && !state_reg.rvalid;
  assign s_axi_awready_out = !state_reg.aw_held;
  assign s_axi_wready_out = !state_reg.w_held;
  assign s_axi_arready_out = !state_reg.rvalid;

  // Byte-lane merge of write data
  always_comb begin
    wr_val = RESET_ZERO;
    for (int b = 0; b < 4; b++) begin
      wr_val[8*b +: 8] = state_reg.w_strb[b] ? state_reg.w_data[8*b +: 8] : 8'h00;
    end
  end

  // Per-counter masks, read and write selects
  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi++) begin : g_cnt
      assign cnt_mask[gi] = (32'h0000_0001 << CW[gi]) - 32'h0000_0001;
      assign cnt_rd[gi] = rd_go && (s_axi_araddr_in == COFS[gi]);
      assign cnt_wr[gi] = wr_go && (state_reg.aw_addr == COFS[gi]) &&
                          state_reg.net_ctrl[BIT_STATS_WRITE];
      // Step by one unless already all ones
      assign cnt_step[gi] = (state_reg.cnt[gi] == cnt_mask[gi]) ?
        state_reg.cnt[gi] : state_reg.cnt[gi] + 32'h0000_0001;
    end
  endgenerate

  // Read multiplexer
  always_comb begin
    rd_val = RESET_ZERO;
    rd_hit = 1'b1;
    unique case (s_axi_araddr_in)
      OFS_NET_CTRL: rd_val = state_reg.net_ctrl;
      OFS_TYPE_ID: rd_val = {16'h0000, state_reg.type_id};
      OFS_USER_IO: rd_val = {30'h0000_0000, state_reg.user_io};
      default: begin
        rd_hit = |cnt_rd;
        for (int i = 0; i < NCNT; i++) begin
          if (cnt_rd[i]) begin
            rd_val = state_reg.cnt[i] & cnt_mask[i];
          end
        end
      end
    endcase
  end

  // Write target check
  always_comb begin
    wr_hit = 1'b0;
    for (int i = 0; i < NCNT; i++) begin
      if (state_reg.aw_addr == COFS[i]) begin
        wr_hit = 1'b1;
      end
    end
    if (state_reg.aw_addr == OFS_NET_CTRL || state_reg.aw_addr == OFS_TYPE_ID ||
        state_reg.aw_addr == OFS_USER_IO) begin
      wr_hit = 1'b1;
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next = state_reg;
    // Address and data capture in either order
    if (s_axi_awvalid_in && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata_in;
      state_next.w_strb = s_axi_wstrb_in;
    end
    if (wr_go) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      unique case (state_reg.aw_addr)
        OFS_NET_CTRL: state_next.net_ctrl = wr_val;
        OFS_TYPE_ID: state_next.type_id = wr_val[TYPE_ID_W-1:0];
        OFS_USER_IO: state_next.user_io = wr_val[1:0];
        default: ;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready_in) begin
      state_next.bvalid = 1'b0;
    end
    if (rd_go) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd_val;
      state_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (state_reg.rvalid && s_axi_rready_in) begin
      state_next.rvalid = 1'b0;
    end
    // Counter update: write, then clear on read, then event
    for (int i = 0; i < NCNT; i++) begin
      if (cnt_wr[i]) begin
        state_next.cnt[i] = wr_val & cnt_mask[i];
      end else if (cnt_rd[i]) begin
        state_next.cnt[i] = event_hit[i] ? 32'h0000_0001 : RESET_ZERO;
      end else if (event_hit[i]) begin
        state_next.cnt[i] = cnt_step[i];
      end
    end
    // Type field comparison per received frame
    if (rx_done_in) begin
      state_next.type_match = (rx_type_field_in == state_reg.type_id);
    end
  end

  // ****************************************
  // Bus timing summary
  // ****************************************
  // Write address and data are taken in either order
  // Each ready drops once its channel is held
  // The response is raised one edge after both are held
  // The response stands until bready is seen high
  // A new write waits for the old response to go
  //
  // The read address is taken while no data stands
  // Read data is registered at the address edge
  // Read data stands until rready is seen high
  // Address ready follows the data valid inverted
  //
  // Read clear happens at the address edge
  // The value returned is the value before clear
  // Software sees each frame exactly once until the counter saturates
  //
  // Write gating for counters
  // Control bit seven opens counter writes
  // A closed gate still answers okay
  // The stored count then stays untouched
  //
  // Byte strobes
  // Unstrobed bytes are written as zero
  // Partial writes therefore clear other bytes
  // Software should write whole words
  //
  // Reset
  // Every state bit returns to zero
  // Both valids fall, all readies rise
  // The transceiver clock is gated off
  // MII operation is selected again
  //
  // Hazards avoided
  // No output depends on bus inputs combinationally
  // except the three readies from held flags
  // Counters never wrap, so no false small value
  // Length window uses the stored big-frame bit
  // Frames over the window are never counted here
  //
  // State register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_bvalid_out = state_reg.bvalid;
  assign s_axi_bresp_out = state_reg.bresp;
  assign s_axi_rvalid_out = state_reg.rvalid;
  assign s_axi_rdata_out = state_reg.rdata;
  assign s_axi_rresp_out = state_reg.rresp;
  assign rx_type_match_out = state_reg.type_match;
  assign rmii_select_out = state_reg.user_io[BIT_RMII_SEL];
  assign phy_clk_gated_out = phy_clk_in & state_reg.user_io[BIT_CLK_EN];

endmodule // msc_stats

`default_nettype wire

// File: verilog/msc_pkg.sv
// Purpose: Constants for the MAC statistics counter bank
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Offsets are byte addresses of aligned words
package msc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_NET_CTRL = 8'h00;
  localparam logic [7:0] OFS_TYPE_ID = 8'h04;
  localparam logic [7:0] OFS_USER_IO = 8'h08;
  localparam logic [7:0] OFS_PAUSE_RX = 8'h10;
  localparam logic [7:0] OFS_TX_OK = 8'h14;
  localparam logic [7:0] OFS_ONE_COL = 8'h18;
  localparam logic [7:0] OFS_MULTI_COL = 8'h1C;
  localparam logic [7:0] OFS_RX_OK = 8'h20;
  localparam logic [7:0] OFS_CRC_ERR = 8'h24;
  localparam logic [7:0] OFS_ALIGN_ERR = 8'h28;
  localparam logic [7:0] OFS_DEFER = 8'h2C;
  localparam int ADDR_W = 8;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_RX_ENABLE = 2;
  localparam int BIT_STATS_WRITE = 7;
  localparam int BIT_BIG_FRAMES = 8;
  localparam int BIT_RMII_SEL = 0;
  localparam int BIT_CLK_EN = 1;
  localparam int TYPE_ID_W = 16;
  localparam int NCNT = 8;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  // ****************************************
  // Counter widths and frame lengths
  // ****************************************
  localparam int W_PAUSE = 16;
  localparam int W_TXOK = 24;
  localparam int W_ONECOL = 16;
  localparam int W_MULTICOL = 16;
  localparam int W_RXOK = 24;
  localparam int W_CRC = 8;
  localparam int W_ALIGN = 8;
  localparam int W_DEFER = 16;
  localparam logic [10:0] LEN_MIN = 11'h040;
  localparam logic [10:0] LEN_MAX = 11'h5EE;
  localparam logic [10:0] LEN_MAX_BIG = 11'h600;
  localparam logic [4:0] COL_MULTI_MAX = 5'h0F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: tb/msc_phy_model.sv
// Purpose: Transceiver clock source
// Assumes: Clock runs only while run_in is high
// Notes: Half period is a parameter
`timescale 1ns/1ps
`default_nettype none
module msc_phy_model #(
  parameter int HALF = 20
) (
  input wire logic run_in,
  output logic phy_clk_out
);
  // Clock stands low when idle
  initial begin
    phy_clk_out = 1'h0;
    forever #(HALF) phy_clk_out = run_in && !phy_clk_out;
  end
endmodule // msc_phy_model
`default_nettype wire

// File: tb/msc_stats_assertions.sv
// Purpose: Port checks on msc_stats
// Assumes: Offsets from msc_pkg
// Notes: Bind after the module
`timescale 1ns/1ps
`default_nettype none
module msc_stats_assertions (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [msc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic phy_clk_in,
  input wire logic phy_clk_gated_out
);
  import msc_pkg::*;
  logic [ADDR_W-1:0] ra_reg;
  // ****
  // Read address capture
  // ****
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ra_reg <= 8'h00;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      ra_reg <= s_axi_araddr_in;
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  // Handshake, clock gate and field width checks
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read late");
  a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read dropped");
  a_clk_gate: assert property (!phy_clk_in |-> !phy_clk_gated_out)
    else $error("clock leak");
  a_pause_width: assert property (s_axi_rvalid_out && ra_reg == OFS_PAUSE_RX |->
    s_axi_rdata_out[31:16] == 16'h0000) else $error("pause wide");
  a_txok_width: assert property (s_axi_rvalid_out && ra_reg == OFS_TX_OK |->
    s_axi_rdata_out[31:24] == 8'h00) else $error("tx wide");
  a_crc_width: assert property (s_axi_rvalid_out && ra_reg == OFS_CRC_ERR |->
    s_axi_rdata_out[31:8] == 24'h000000) else $error("crc wide");
  a_align_width: assert property (s_axi_rvalid_out && ra_reg == OFS_ALIGN_ERR |->
    s_axi_rdata_out[31:8] == 24'h000000) else $error("align wide");
  a_defer_width: assert property (s_axi_rvalid_out && ra_reg == OFS_DEFER |->
    s_axi_rdata_out[31:16] == 16'h0000) else $error("defer wide");
endmodule // msc_stats_assertions
bind msc_stats msc_stats_assertions u_msc_stats_assertions (.clk_sys_in, .rst_n_in,
  .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .s_axi_rdata_out, .phy_clk_in, .phy_clk_gated_out);
`default_nettype wire

// File: tb/test_msc_stats.sv
// Purpose: Self-checking bench for msc_stats
// Assumes: Frame strobes last one cycle
// Notes: Each row is one frame and the counters it bumps
`timescale 1ns/1ps
`default_nettype none
module test_msc_stats;
  import msc_pkg::*;
  typedef struct packed {
    logic rx, un, re;
    logic [4:0] col;
    logic df;
    logic [10:0] len;
    logic wh, crc, sy, pa, cp;
    logic [7:0] m;
  } msc_row_type;
  logic clk = 1'h0, rst_n = 1'h0, dn = 1'h0, run = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0;
  logic awr, wr, bv, arr, rv, pck, pg, rm, tm;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] bre, rre;
  logic [15:0] ty = 16'h0000;
  msc_row_type ri = '0;
  int n_errors = 0, checks_done = 0, cyc = 0, n_edge = 0;
  msc_row_type rows [16] = '{
    '{0,0,0,0,0,64,1,0,0,0,0,8'h02},
    '{0,0,0,1,0,64,1,0,0,0,0,8'h06},
    '{0,0,0,2,0,64,1,0,0,0,0,8'h0A},
    '{0,0,0,15,0,64,1,0,0,0,0,8'h0A},
    '{0,0,1,16,0,64,1,0,0,0,0,8'h00},
    '{0,1,0,1,1,64,1,0,0,0,0,8'h00},
    '{0,0,0,0,1,64,1,0,0,0,0,8'h82},
    '{0,0,0,1,1,64,1,0,0,0,0,8'h06},
    '{1,0,0,0,0,64,1,0,0,0,1,8'h10},
    '{1,0,0,0,0,1518,1,0,0,1,0,8'h01},
    '{1,0,0,0,0,1518,1,1,0,0,1,8'h20},
    '{1,0,0,0,0,63,1,1,0,0,1,8'h00},
    '{1,0,0,0,0,64,0,1,0,0,1,8'h40},
    '{1,0,0,0,0,100,1,0,1,0,1,8'h20},
    '{1,0,0,0,0,100,0,0,1,0,1,8'h40},
    '{1,0,0,0,0,1519,1,0,0,0,1,8'h00}
  };
  msc_stats u_msc_stats (
    .clk_sys_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(bre), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'h1),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rre), .s_axi_rvalid_out(rv), .s_axi_rready_in(1'h1),
    .tx_done_in(dn && !ri.rx), .tx_underrun_in(ri.un), .tx_retry_exceeded_in(ri.re),
    .tx_collisions_in(ri.col), .tx_deferred_in(ri.df), .rx_done_in(dn && ri.rx),
    .rx_length_in(ri.len), .rx_whole_bytes_in(ri.wh), .rx_crc_bad_in(ri.crc),
    .rx_symbol_err_in(ri.sy), .rx_is_pause_in(ri.pa), .rx_copied_in(ri.cp),
    .rx_type_field_in(ty), .rx_type_match_out(tm), .rmii_select_out(rm), .phy_clk_in(pck),
    .phy_clk_gated_out(pg));
  msc_phy_model u_msc_phy_model (.run_in(run), .phy_clk_out(pck));
  // Clock, gated clock edges and hang guard
  always #2 clk = !clk;
  always @(posedge pg) n_edge++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus write: hold each channel until taken, wait for response
  task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ha, hw, hb;
    logic [1:0] r;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    hb = 1'h0;
    while (!hb) begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wr;
      hb = bv;
      r = bre;
      @(posedge clk);
      if (ha) awv <= 1'h0;
      if (hw) wv <= 1'h0;
    end
    cmp(32'(r), 32'(e));
  endtask
  // Bus read: hold address until taken, wait for data
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic hr, hd;
    logic [31:0] g;
    logic [1:0] r;
    ara <= a;
    arv <= 1'h1;
    hd = 1'h0;
    while (!hd) begin
      @(negedge clk);
      hr = arv && arr;
      hd = rv;
      g = rdat;
      r = rre;
      @(posedge clk);
      if (hr) arv <= 1'h0;
    end
    cmp(g, d);
    cmp(32'(r), 32'(e));
  endtask
  task automatic ev(input msc_row_type r);
    ri <= r;
    dn <= 1'h1;
    @(posedge clk);
    dn <= 1'h0;
    @(posedge clk);
  endtask
  task automatic all8(input logic [7:0] m);
    for (int i = 0; i < NCNT; i++) begin
      rd(8'(OFS_PAUSE_RX + 4 * i), 32'(m[i]), RESP_OKAY);
    end
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    all8(8'h00);
    rd(OFS_USER_IO, 32'h0, RESP_OKAY);
    wrt(OFS_NET_CTRL, 32'h4, RESP_OKAY);
    foreach (rows[i]) begin
      ev(rows[i]);
      all8(rows[i].m);
    end
    wrt(OFS_NET_CTRL, 32'h0, RESP_OKAY);
    ev(rows[8]);
    all8(8'h00);
    wrt(OFS_NET_CTRL, 32'h104, RESP_OKAY);
    ev('{1,0,0,0,0,1536,1,0,0,0,1,8'h10});
    all8(8'h10);
    wrt(OFS_TX_OK, 32'hFFFFFF, RESP_OKAY);
    rd(OFS_TX_OK, 32'h0, RESP_OKAY);
    wrt(OFS_NET_CTRL, 32'h84, RESP_OKAY);
    wrt(OFS_TX_OK, 32'hFFFFFF, RESP_OKAY);
    wrt(OFS_CRC_ERR, 32'hFF, RESP_OKAY);
    ev(rows[0]);
    rd(OFS_TX_OK, 32'hFFFFFF, RESP_OKAY);
    rd(OFS_TX_OK, 32'h0, RESP_OKAY);
    rd(OFS_CRC_ERR, 32'hFF, RESP_OKAY);
    wrt(OFS_TYPE_ID, 32'h88F7, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      ty <= 16'h88F7 ^ 16'(k);
      ev(rows[8]);
      @(negedge clk);
      cmp(32'(tm), 32'(k == 0));
    end
    @(posedge clk);
    run <= 1'h1;
    for (int k = 3; k >= 0; k -= 3) begin
      wrt(OFS_USER_IO, 32'(k), RESP_OKAY);
      n_edge = 0;
      repeat (40) @(posedge clk);
      cmp(32'(rm), 32'(k != 0));
      cmp(32'(n_edge != 0), 32'(k != 0));
    end
    rd(8'h0C, 32'h0, RESP_SLVERR);
    wrt(8'h30, 32'h1, RESP_SLVERR);
    // Mid-run reset clears counters; user I/O is already zero before it
    ev(rows[0]);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    all8(8'h00);
    cmp(32'(rm), 32'h0);
    stop_test();
  end
endmodule // test_msc_stats
`default_nettype wire
